// ---- core/cal_top.sv ----
// Command/address latency capture for the command port
module cal_top (
  input wire logic core_clk, // 10 MHz command clock
  input wire logic reset, // Sync reset, active high
  input wire logic cs_n, // Chip select, active low
  input wire logic [cal_pkg::CMD_W-1:0] cmd_in, // Command bus
  input wire logic [cal_pkg::ADDR_W-1:0] addr_in, // Address bus
  input wire logic odt_in, // Termination control
  output logic cmd_valid, // Captured command strobe
  output logic [cal_pkg::CMD_W-1:0] cmd_out, // Captured command
  output logic [cal_pkg::ADDR_W-1:0] addr_out, // Captured address
  output logic rcv_on, // Receiver enable
  output logic cal_en, // Latency feature on
  output logic [cal_pkg::LAT_W-1:0] cal_lat, // Latency in clocks
  output logic odt_out // Termination, fixed pipe
);
  typedef struct packed {
    logic en;
    logic [cal_pkg::LAT_W-1:0] lat;
    logic vld;
    logic [cal_pkg::CMD_W-1:0] cmd;
    logic [cal_pkg::ADDR_W-1:0] addr;
    logic rcv;
    logic [cal_pkg::LAT_W:0] hold;
    logic odt;
  } cal_st_t;
  cal_st_t st_r;
  cal_st_t st_nxt;
  logic cs_low;
  logic eff_zero;
  cal_if dbus ();
  assign cs_low = ~cs_n;
  // Disabled feature forces zero delay through the line
  assign eff_zero = ~st_r.en;
  assign dbus.cs_low = cs_low;
  assign dbus.cmd = cmd_in;
  assign dbus.addr = addr_in;
  assign dbus.lat = eff_zero ? 3'h0 : st_r.lat;
  cal_delay u_dly (
    .core_clk(core_clk),
    .reset(reset),
    .bus(dbus)
  );
  // Next state: capture, mode update, receiver power
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.vld = 1'b0;
    if (dbus.tap_valid)
    begin
      st_nxt.vld = 1'b1;
      st_nxt.cmd = dbus.tap_cmd;
      st_nxt.addr = dbus.tap_addr;
      // mode command sets feature and count
      if (dbus.tap_cmd == cal_pkg::CMD_MRS)
      begin
        st_nxt.en = dbus.tap_addr[cal_pkg::CAL_EN_POS];
        st_nxt.lat = dbus.tap_addr[cal_pkg::CAL_LAT_POS +: cal_pkg::LAT_W];
      end
    end
    // keep receivers on while CS low or captures pending
    // Reload on every CS low, so back-to-back commands never drop power
    if (cs_low)
      st_nxt.hold = {1'b0, dbus.lat} + 4'h1;
    else if (st_r.hold != 4'h0)
      st_nxt.hold = st_r.hold - 4'h1;
    // power off once pending captures drain and CS high, only while the feature is on
    st_nxt.rcv = cs_low | (st_nxt.hold != 4'h0) | ~st_r.en;
    // fixed termination pipe regardless of latency
    st_nxt.odt = odt_in;
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.en <= cal_pkg::EN_RST;
      st_r.lat <= cal_pkg::LAT_RST;
      st_r.rcv <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end
  assign cmd_valid = st_r.vld;
  assign cmd_out = st_r.cmd;
  assign addr_out = st_r.addr;
  assign rcv_on = st_r.rcv;
  assign cal_en = st_r.en;
  assign cal_lat = st_r.lat;
  assign odt_out = st_r.odt;
  // Assertions share the one command clock and the sync reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_zero_capture: assert property (
    (!st_r.en && !cs_n)
    |=> cmd_valid && cmd_out == $past(cmd_in))
    else $error("capture missing with latency off");

  // captured word is the bus at the capture edge
  a_lat_capture: assert property (
    cmd_valid
    |-> cmd_out == $past(cmd_in) && addr_out == $past(addr_in))
    else $error("latency capture wrong");

  // exact distance per latency; a mid-flight change is excluded
  a_lat_one: assert property (
    (st_r.en && st_r.lat == 3'h1 && !cs_n) ##1
    (st_r.en && st_r.lat == 3'h1) [*1]
    |=> cmd_valid)
    else $error("capture not one clock after CS");

  a_lat_two: assert property (
    (st_r.en && st_r.lat == 3'h2 && !cs_n) ##1
    (st_r.en && st_r.lat == 3'h2) [*2]
    |=> cmd_valid)
    else $error("capture not two clocks after CS");

  a_lat_three: assert property (
    (st_r.en && st_r.lat == 3'h3 && !cs_n) ##1
    (st_r.en && st_r.lat == 3'h3) [*3]
    |=> cmd_valid)
    else $error("capture not three clocks after CS");

  a_lat_four: assert property (
    (st_r.en && st_r.lat == 3'h4 && !cs_n) ##1
    (st_r.en && st_r.lat == 3'h4) [*4]
    |=> cmd_valid)
    else $error("capture not four clocks after CS");

  a_lat_five: assert property (
    (st_r.en && st_r.lat == 3'h5 && !cs_n) ##1
    (st_r.en && st_r.lat == 3'h5) [*5]
    |=> cmd_valid)
    else $error("capture not five clocks after CS");

  a_lat_six: assert property (
    (st_r.en && st_r.lat == 3'h6 && !cs_n) ##1
    (st_r.en && st_r.lat == 3'h6) [*6]
    |=> cmd_valid)
    else $error("capture not six clocks after CS");

  // longest latency the field can hold
  a_lat_seven: assert property (
    (st_r.en && st_r.lat == 3'h7 && !cs_n) ##1
    (st_r.en && st_r.lat == 3'h7) [*7]
    |=> cmd_valid)
    else $error("capture not seven clocks after CS");

  // no capture strobe without a fired tap
  a_vld_src: assert property (
    cmd_valid
    |-> $past(dbus.tap_valid))
    else $error("capture strobe without tap");

  a_out_hold: assert property (
    !dbus.tap_valid
    |=> $stable(cmd_out) && $stable(addr_out))
    else $error("captured word changed without capture");

  a_mode_set: assert property (
    (dbus.tap_valid && dbus.tap_cmd == cal_pkg::CMD_MRS)
    |=> cal_en == $past(dbus.tap_addr[cal_pkg::CAL_EN_POS]))
    else $error("mode command did not update enable");

  a_lat_field: assert property (
    (dbus.tap_valid && dbus.tap_cmd == cal_pkg::CMD_MRS)
    |=> cal_lat == $past(dbus.tap_addr[cal_pkg::CAL_LAT_POS +: 3]))
    else $error("mode command did not update latency");

  a_rcv_held: assert property (
    !cs_n
    |=> rcv_on)
    else $error("receivers off during CS low");

  // receivers never gated while the feature is off
  a_rcv_dis: assert property (
    !cal_en
    |=> rcv_on)
    else $error("receivers off with latency off");

  a_rcv_off: assert property (
    (cal_en && cs_n && st_r.hold == 4'h0)
    |=> !rcv_on)
    else $error("receivers not released");

  a_odt_fixed: assert property (
    1'b1
    |=> odt_out == $past(odt_in))
    else $error("termination timing shifted");

  // count only moves on a mode command
  a_lat_stable: assert property (
    !(dbus.tap_valid && dbus.tap_cmd == cal_pkg::CMD_MRS)
    |=> $stable(cal_lat))
    else $error("latency changed without mode command");

  // Main scenarios to be reached
  c_enable: cover property ($rose(cal_en));
  c_back2back: cover property ((cal_en && !cs_n) [*3]);
  c_rcv_off: cover property ($fell(rcv_on));
  c_lat_change: cover property (cal_en && $changed(cal_lat));
  c_disable: cover property ($fell(cal_en));
endmodule : cal_top

// ---- core/cal_pkg.sv ----
// Package for the command/address latency block
package cal_pkg;
  localparam int CMD_W = 8;
  localparam int ADDR_W = 18;
  localparam int LAT_W = 3;
  localparam int MAX_LAT = 8;
  localparam logic [LAT_W-1:0] LAT_RST = 3'h0;
  localparam logic EN_RST = 1'b0;
  localparam int CAL_LAT_POS = 0;
  localparam int CAL_EN_POS = 3;
  localparam int ODT_PIPE = 1;
  localparam logic [CMD_W-1:0] CMD_MRS = 8'h01;
  localparam int CLK_PERIOD_NS = 100;
endpackage : cal_pkg

// ---- core/cal_if.sv ----
// Interface carrying the delay line request and answer
interface cal_if;
  logic [cal_pkg::CMD_W-1:0] cmd;
  logic [cal_pkg::ADDR_W-1:0] addr;
  logic [cal_pkg::LAT_W-1:0] lat;
  logic cs_low;
  logic tap_valid;
  logic [cal_pkg::CMD_W-1:0] tap_cmd;
  logic [cal_pkg::ADDR_W-1:0] tap_addr;
  modport src (output cmd, addr, lat, cs_low,
    input tap_valid, tap_cmd, tap_addr);
  modport dly (input cmd, addr, lat, cs_low,
    output tap_valid, tap_cmd, tap_addr);
endinterface : cal_if

// ---- core/cal_delay.sv ----
// Programmable delay line for CS and command/address capture
module cal_delay (
  input wire logic core_clk, // Clock
  input wire logic reset, // Sync reset
  cal_if.dly bus // Delay request and tap
);
  typedef struct packed {
    logic [cal_pkg::MAX_LAT-1:0] cs_sh;
  } cal_dly_st_t;
  cal_dly_st_t st_r;
  cal_dly_st_t st_nxt;
  logic [cal_pkg::MAX_LAT-1:0] sh_in;
  // Shift chain of CS markers, one flop per clock of delay
  genvar g;
  generate
    for (g = 0; g < cal_pkg::MAX_LAT; g++)
    begin : g_sh
      if (g == 0)
      begin : g_first
        assign sh_in[g] = bus.cs_low;
      end
      else
      begin : g_rest
        assign sh_in[g] = st_r.cs_sh[g-1];
      end
    end
  endgenerate
  always_comb
  begin
    st_nxt.cs_sh = sh_in;
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  // Tap chooses delayed CS; bus is sampled when the tap fires
  assign bus.tap_valid = (bus.lat == '0) ? bus.cs_low
                         : st_r.cs_sh[bus.lat - 3'h1];
  assign bus.tap_cmd = bus.cmd;
  assign bus.tap_addr = bus.addr;
endmodule : cal_delay

// ---- sim/cal_ctl_model.sv ----
// Controller model driving the command port
module cal_ctl_model (
  input wire logic core_clk, // Command clock
  output logic cs_n = 1'b1, // Chip select, active low
  output logic [cal_pkg::CMD_W-1:0] cmd_in = '0, // Command bus
  output logic [cal_pkg::ADDR_W-1:0] addr_in = '0 // Address bus
);
  timeunit 1ns;
  timeprecision 1ns;
  // latency in whole clocks, from the current setting
  task automatic send(input logic [cal_pkg::CMD_W-1:0] c,
    input logic [cal_pkg::ADDR_W-1:0] a, input int l);
    @(posedge core_clk) #1;
    cs_n = 1'b0;
    // No latency: the word stands with the select
    if (l == 0)
    begin
      cmd_in = c;
      addr_in = a;
    end
    for (int i = 0; i < l; i++)
    begin
      @(posedge core_clk) #1;
      cs_n = 1'b1;
    end
    // Latency: the word stands at the L-th edge after the select
    if (l != 0)
    begin
      cmd_in = c;
      addr_in = a;
    end
    @(posedge core_clk) #1;
    cs_n = 1'b1;
    // Inverse value, so a late capture never sees the command
    cmd_in = ~c;
    addr_in = ~a;
  endtask : send
endmodule : cal_ctl_model

// ---- sim/testbench.sv ----
// Self-checking bench for the command/address latency block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MOD_DLY = 4; // Update delay, plain default
  logic core_clk, reset, cs_n, odt_in, cmd_valid, rcv_on, cal_en, odt_out;
  logic [cal_pkg::CMD_W-1:0] cmd_in, cmd_out;
  logic [cal_pkg::ADDR_W-1:0] addr_in, addr_out;
  logic [cal_pkg::LAT_W-1:0] cal_lat;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  cal_top cal_top_inst (.core_clk, .reset, .cs_n, .cmd_in, .addr_in,
    .odt_in, .cmd_valid, .cmd_out, .addr_out, .rcv_on, .cal_en, .cal_lat,
    .odt_out);
  cal_ctl_model cal_ctl_model_inst (.core_clk, .cs_n, .cmd_in, .addr_in);
  // Clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      error_cnt++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // Latency off: capture on the select edge
  task automatic t_plain;
    cal_ctl_model_inst.send(8'h5A, 18'h2A5C3, 0);
    check("valid", cmd_valid, 1'b1);
    check("cmd", cmd_out, 8'h5A);
    check("addr", addr_out, 18'h2A5C3);
    check("en", cal_en, 1'b0);
  endtask : t_plain
  // Mode command sets latency; the task then waits out the update delay plus the new latency
  task automatic t_mrs(input int l, input int l_old);
    cal_ctl_model_inst.send(cal_pkg::CMD_MRS, {15'h0001, l[2:0]}, l_old);
    check("en", cal_en, 1'b1);
    check("lat", cal_lat, l);
    // wait update delay plus new latency
    repeat (MOD_DLY + l) @(posedge core_clk);
  endtask : t_mrs
  // Mode command clears the feature; capture returns to the CS edge
  task automatic t_off(input int l_old);
    cal_ctl_model_inst.send(cal_pkg::CMD_MRS, 18'h00000, l_old);
    check("en off", cal_en, 1'b0);
    check("lat off", cal_lat, 3'h0);
    repeat (MOD_DLY + l_old) @(posedge core_clk);
  endtask : t_off
  // Latency on: late capture, termination unshifted, receivers drop
  task automatic t_late(input int l);
    cal_ctl_model_inst.send(8'hC3, 18'h1F00E, l);
    check("valid", cmd_valid, 1'b1);
    check("cmd", cmd_out, 8'hC3);
    check("addr", addr_out, 18'h1F00E);
    check("rcv", rcv_on, 1'b1);
    odt_in = 1'b1;
    @(posedge core_clk) #1;
    check("pulse", cmd_valid, 1'b0);
    check("odt", odt_out, 1'b1);
    odt_in = 1'b0;
    repeat (l + 2) @(posedge core_clk);
    #1;
    check("rcv off", rcv_on, 1'b0);
  endtask : t_late
  // Main sequence
  initial
  begin
    reset = 1'b1;
    odt_in = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 reset = 1'b0;
    t_plain();
    t_mrs(3, 0);
    t_late(3);
    t_mrs(5, 3);
    t_late(5);
    t_off(5);
    t_plain();
    conclude();
  end
endmodule : testbench
